// ===== design/ubrg_params.svh
`ifndef UBRG_PARAMS_SVH
`define UBRG_PARAMS_SVH

// Byte offsets on the register bus
`define UBRG_OFF_PRESCALE0   8'h00
`define UBRG_OFF_PRESCALE1   8'h04
`define UBRG_OFF_START       8'h08
`define UBRG_OFF_STOP        8'h0c
`define UBRG_OFF_MODE_BASE   8'h10
`define UBRG_OFF_DATA_BASE   8'h30
`define UBRG_OFF_STATUS      8'h50

// Field positions
`define UBRG_CLK_SRC_BIT     15
`define UBRG_DIV_MSB         15
`define UBRG_DIV_LSB         9
`define UBRG_FRAME_MSB       3
`define UBRG_FRAME_LSB       0
`define UBRG_LOW_FIELD_LSB   0
`define UBRG_HIGH_FIELD_LSB  4

// Reset values
`define UBRG_PRESCALE_RST    8'h00
`define UBRG_DIV_RST         7'h40
`define UBRG_FRAME_RST       4'ha
`define UBRG_CLK_SRC_RST     1'b0

// Prescaler
`define UBRG_PS_CNT_W        11
`define UBRG_TAP_COUNT       12
`define UBRG_TIMER_CODE      4'hf

`endif

// ===== design/ubrg_pkg.sv
package ubrg_pkg;
	typedef logic [6:0] ubrg_div_type;
	typedef logic [3:0] ubrg_code_type;
	typedef enum logic {
		UBRG_RX_IDLE,
		UBRG_RX_BUSY
	} ubrg_rx_state_type;
endpackage : ubrg_pkg

// ===== design/ubrg_prescale.sv
`timescale 1ns/10ps
`include "ubrg_params.svh"
module ubrg_prescale import ubrg_pkg::*; (
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	input  wire logic [7:0] select,
	input  wire logic       timer_event,
	output logic            en_low,
	output logic            en_high
);
	logic [`UBRG_PS_CNT_W-1:0] cnt_r;
	logic [`UBRG_PS_CNT_W-1:0] cnt_nxt;

	// Code k gives one enable every 2^k system clocks; 12 to 14 give none
	function automatic logic tap_sel(ubrg_code_type code, logic [`UBRG_PS_CNT_W-1:0] cnt, logic tev);
		logic [`UBRG_TAP_COUNT-1:0] taps;
		logic [`UBRG_PS_CNT_W-1:0]  mask;
		taps = '0;
		mask = '0;
		taps[0] = 1'b1;
		for (int j = 1; j < `UBRG_TAP_COUNT; j++) begin
			mask[j-1] = 1'b1;
			taps[j] = &(cnt | ~mask);
		end
		if (code == `UBRG_TIMER_CODE)
			tap_sel = tev;
		else if (code < ubrg_code_type'(`UBRG_TAP_COUNT))
			tap_sel = taps[code];
		else
			tap_sel = 1'b0;
	endfunction : tap_sel

	always_comb begin
		cnt_nxt = cnt_r + `UBRG_PS_CNT_W'('h1);
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			cnt_r <= '0;
		else if (ce)
			cnt_r <= cnt_nxt;
	end

	assign en_low  = tap_sel(select[`UBRG_LOW_FIELD_LSB +: 4], cnt_r, timer_event);
	assign en_high = tap_sel(select[`UBRG_HIGH_FIELD_LSB +: 4], cnt_r, timer_event);

	a_timer_route: assert property (@(posedge sys_clk) disable iff (!rstn)
		(select[3:0] == 4'hf) |-> (en_low == timer_event))
		else $error("timer code does not route timer event");
	a_reserved_code: assert property (@(posedge sys_clk) disable iff (!rstn)
		(select[7:4] inside {4'hc, 4'hd, 4'he}) |-> !en_high)
		else $error("prohibited code produced an enable");
	a_tap_spacing: assert property (@(posedge sys_clk) disable iff (!rstn)
		(ce && en_low && select[3:0] == 4'h2 && $stable(select)) |=> (ce && select[3:0] == 4'h2) |-> !en_low)
		else $error("divide by four tap fired on adjacent cycles");
	c_timer_clock: cover property (@(posedge sys_clk) disable iff (!rstn)
		select[7:4] == 4'hf && en_high);
endmodule : ubrg_prescale

// ===== design/ubrg_divider.sv
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`include "ubrg_params.svh"
module ubrg_divider import ubrg_pkg::*; (
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	input  wire logic         ce,
	input  wire logic         op_en,
	input  wire logic         run,
	input  wire ubrg_div_type div,
	input  wire logic [3:0]   frame_len,
	input  wire logic         rxd,
	output logic              half_tick,
	output logic              bit_tick,
	output logic              rx_sample,
	output logic              rx_bit,
	output logic              rx_done,
	output logic              rx_err,
	output logic              rx_busy
);
	ubrg_div_type      tx_cnt_r, tx_cnt_nxt;
	logic              phase_r, phase_nxt;
	logic              half_r, half_nxt;
	logic              bit_r, bit_nxt;
	ubrg_rx_state_type state_r, state_nxt;
	ubrg_div_type      rx_cnt_r, rx_cnt_nxt;
	logic              rx_phase_r, rx_phase_nxt;
	logic [3:0]        nsamp_r, nsamp_nxt;
	logic              rx_prev_r, rx_prev_nxt;
	logic              samp_r, samp_nxt;
	logic              sbit_r, sbit_nxt;
	logic              done_r, done_nxt;
	logic              err_r, err_nxt;

	// Transmit-side rate: one half tick per div+1 operation clocks
	always_comb begin
		tx_cnt_nxt = tx_cnt_r;
		phase_nxt  = phase_r;
		half_nxt   = 1'b0;
		bit_nxt    = 1'b0;
		if (!run) begin
			tx_cnt_nxt = '0;
			phase_nxt  = 1'b0;
		end else if (op_en) begin
			if (tx_cnt_r == div) begin
				tx_cnt_nxt = '0;
				half_nxt   = 1'b1;
				phase_nxt  = ~phase_r;
				bit_nxt    = phase_r;
			end else
				tx_cnt_nxt = tx_cnt_r + 7'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tx_cnt_r <= '0;
			phase_r  <= 1'b0;
			half_r   <= 1'b0;
			bit_r    <= 1'b0;
		end else if (ce) begin
			tx_cnt_r <= tx_cnt_nxt;
			phase_r  <= phase_nxt;
			half_r   <= half_nxt;
			bit_r    <= bit_nxt;
		end
	end

	// Receive timing: first reload lands mid start bit, then every second one
	always_comb begin
		state_nxt    = state_r;
		rx_cnt_nxt   = rx_cnt_r;
		rx_phase_nxt = rx_phase_r;
		nsamp_nxt    = nsamp_r;
		rx_prev_nxt  = rxd;
		samp_nxt     = 1'b0;
		sbit_nxt     = sbit_r;
		done_nxt     = 1'b0;
		err_nxt      = 1'b0;
		case (state_r)
			UBRG_RX_IDLE: begin
				if (run && rx_prev_r && !rxd) begin
					state_nxt    = UBRG_RX_BUSY;
					rx_cnt_nxt   = '0;
					rx_phase_nxt = 1'b0;
					nsamp_nxt    = '0;
				end
			end
			UBRG_RX_BUSY: begin
				if (!run)
					state_nxt = UBRG_RX_IDLE;
				else if (op_en) begin
					if (rx_cnt_r == div) begin
						rx_cnt_nxt   = '0;
						rx_phase_nxt = ~rx_phase_r;
						if (!rx_phase_r) begin
							samp_nxt  = 1'b1;
							sbit_nxt  = rxd;
							nsamp_nxt = nsamp_r + 4'h1;
							// A start bit gone high by mid-bit was a glitch
							if (nsamp_r == 4'h0 && rxd)
								state_nxt = UBRG_RX_IDLE;
							else if (nsamp_r + 4'h1 == frame_len) begin
								done_nxt  = 1'b1;
								err_nxt   = ~rxd;
								state_nxt = UBRG_RX_IDLE;
							end
						end
					end else
						rx_cnt_nxt = rx_cnt_r + 7'h01;
				end
			end
			default: state_nxt = UBRG_RX_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_r    <= UBRG_RX_IDLE;
			rx_cnt_r   <= '0;
			rx_phase_r <= 1'b0;
			nsamp_r    <= '0;
			rx_prev_r  <= 1'b1;
			samp_r     <= 1'b0;
			sbit_r     <= 1'b1;
			done_r     <= 1'b0;
			err_r      <= 1'b0;
		end else if (ce) begin
			state_r    <= state_nxt;
			rx_cnt_r   <= rx_cnt_nxt;
			rx_phase_r <= rx_phase_nxt;
			nsamp_r    <= nsamp_nxt;
			rx_prev_r  <= rx_prev_nxt;
			samp_r     <= samp_nxt;
			sbit_r     <= sbit_nxt;
			done_r     <= done_nxt;
			err_r      <= err_nxt;
		end
	end

	assign half_tick = half_r;
	assign bit_tick  = bit_r;
	assign rx_sample = samp_r;
	assign rx_bit    = sbit_r;
	assign rx_done   = done_r;
	assign rx_err    = err_r;
	assign rx_busy   = (state_r == UBRG_RX_BUSY);

	// Helper: operation clocks seen since the previous half tick
	logic [7:0]   en_cnt_r;
	logic         en_ok_r;
	ubrg_div_type div_q_r;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			en_cnt_r <= '0;
			en_ok_r  <= 1'b0;
			div_q_r  <= '0;
		end else if (ce) begin
			div_q_r <= div;
			if (!run) begin
				en_cnt_r <= '0;
				en_ok_r  <= 1'b1;
			end else begin
				if (div != div_q_r)
					en_ok_r <= 1'b0;
				else if (half_r)
					en_ok_r <= 1'b1;
				if (half_r)
					en_cnt_r <= op_en ? 8'h01 : 8'h00;
				else if (op_en)
					en_cnt_r <= en_cnt_r + 8'h01;
			end
		end
	end

	a_half_period: assert property (@(posedge sys_clk) disable iff (!rstn)
		(half_r && en_ok_r && div == div_q_r) |-> (en_cnt_r == {1'b0, div} + 8'h01))
		else $error("half tick spacing differs from divider plus one");
	a_bit_two_halves: assert property (@(posedge sys_clk) disable iff (!rstn)
		bit_r |-> (half_r && !phase_r))
		else $error("bit tick without closing half tick");
	a_rx_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
		(ce && run && state_r == UBRG_RX_IDLE && rx_prev_r && !rxd) |=> (rx_busy && rx_cnt_r == 7'h00 && nsamp_r == 4'h0))
		else $error("start edge did not restart receive timing");
	a_frame_count: assert property (@(posedge sys_clk) disable iff (!rstn)
		done_r |-> (samp_r && nsamp_r == frame_len && !rx_busy))
		else $error("frame ended at wrong sample count");
	c_half_tick: cover property (@(posedge sys_clk) disable iff (!rstn) half_r ##[1:300] bit_r);
	c_frame_done: cover property (@(posedge sys_clk) disable iff (!rstn) done_r && !err_r);
endmodule : ubrg_divider

// ===== design/ubrg_top.sv
`timescale 1ns/10ps
`include "ubrg_params.svh"
module ubrg_top import ubrg_pkg::*; (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        timer2_event,
	input  wire logic        timer3_event,
	input  wire logic [7:0]  rxd,
	output logic [7:0]       half_tick,
	output logic [7:0]       bit_tick,
	output logic [7:0]       rx_sample,
	output logic [7:0]       rx_bit,
	output logic [7:0]       rx_frame_done,
	output logic [7:0]       rx_frame_err
);
	logic [1:0][7:0]   ps_r, ps_nxt;
	logic [7:0]        clk_src_r, clk_src_nxt;
	logic [7:0][3:0]   frame_r, frame_nxt;
	ubrg_div_type [7:0] div_r, div_nxt;
	logic [7:0]        run_r, run_nxt;
	logic              ack_r, ack_nxt;
	logic [31:0]       rdata_r, rdata_nxt;
	logic [31:0]       rd_val;
	logic              wr_take;
	logic [3:0]        mode_hit, data_hit;
	logic [1:0]        en_low, en_high;
	logic [1:0]        tev;
	logic [7:0]        op_en;
	logic [7:0]        rx_busy;

	// Returns {hit, channel} for an eight-word register block at base
	function automatic logic [3:0] chan_hit(logic [7:0] addr, logic [7:0] base);
		logic [7:0] rel;
		rel = addr - base;
		chan_hit = {(addr >= base) && (rel < 8'h20) && (rel[1:0] == 2'b00), rel[4:2]};
	endfunction : chan_hit

	assign mode_hit = chan_hit(avs_address, `UBRG_OFF_MODE_BASE);
	assign data_hit = chan_hit(avs_address, `UBRG_OFF_DATA_BASE);
	// Accept on the second cycle so that read data always comes from a flop
	assign wr_take  = avs_write && ack_r;

	always_comb begin
		rd_val = 32'h0000_0000;
		if (avs_address == `UBRG_OFF_PRESCALE0)
			rd_val[7:0] = ps_r[0];
		else if (avs_address == `UBRG_OFF_PRESCALE1)
			rd_val[7:0] = ps_r[1];
		else if (avs_address == `UBRG_OFF_STATUS)
			rd_val[15:0] = {rx_busy, run_r};
		else if (mode_hit[3]) begin
			rd_val[`UBRG_CLK_SRC_BIT] = clk_src_r[mode_hit[2:0]];
			rd_val[`UBRG_FRAME_MSB:`UBRG_FRAME_LSB] = frame_r[mode_hit[2:0]];
		end else if (data_hit[3])
			rd_val[`UBRG_DIV_MSB:`UBRG_DIV_LSB] = div_r[data_hit[2:0]];
	end

	always_comb begin
		ps_nxt      = ps_r;
		clk_src_nxt = clk_src_r;
		frame_nxt   = frame_r;
		div_nxt     = div_r;
		run_nxt     = run_r;
		ack_nxt     = (avs_read || avs_write) && !ack_r;
		rdata_nxt   = rdata_r;
		if (avs_read && !ack_r)
			rdata_nxt = rd_val;
		if (wr_take) begin
			if (avs_address == `UBRG_OFF_PRESCALE0 && avs_byteenable[0])
				ps_nxt[0] = avs_writedata[7:0];
			else if (avs_address == `UBRG_OFF_PRESCALE1 && avs_byteenable[0])
				ps_nxt[1] = avs_writedata[7:0];
			else if (avs_address == `UBRG_OFF_START && avs_byteenable[0])
				run_nxt = run_r | avs_writedata[7:0];
			else if (avs_address == `UBRG_OFF_STOP && avs_byteenable[0])
				run_nxt = run_r & ~avs_writedata[7:0];
			else if (mode_hit[3]) begin
				if (avs_byteenable[1])
					clk_src_nxt[mode_hit[2:0]] = avs_writedata[`UBRG_CLK_SRC_BIT];
				if (avs_byteenable[0])
					frame_nxt[mode_hit[2:0]] = avs_writedata[`UBRG_FRAME_MSB:`UBRG_FRAME_LSB];
			end else if (data_hit[3] && avs_byteenable[1])
				div_nxt[data_hit[2:0]] = avs_writedata[`UBRG_DIV_MSB:`UBRG_DIV_LSB];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ps_r      <= {2{`UBRG_PRESCALE_RST}};
			clk_src_r <= {8{`UBRG_CLK_SRC_RST}};
			frame_r   <= {8{`UBRG_FRAME_RST}};
			div_r     <= {8{`UBRG_DIV_RST}};
			run_r     <= 8'h00;
			ack_r     <= 1'b0;
			rdata_r   <= 32'h0000_0000;
		end else if (ce) begin
			ps_r      <= ps_nxt;
			clk_src_r <= clk_src_nxt;
			frame_r   <= frame_nxt;
			div_r     <= div_nxt;
			run_r     <= run_nxt;
			ack_r     <= ack_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
	assign avs_readdata    = rdata_r;
	assign tev             = {timer3_event, timer2_event};

	genvar u, c;
	generate
		for (u = 0; u < 2; u++) begin : g_unit
			ubrg_prescale u_prescale (
				.sys_clk     (sys_clk),
				.rstn        (rstn),
				.ce          (ce),
				.select      (ps_r[u]),
				.timer_event (tev[u]),
				.en_low      (en_low[u]),
				.en_high     (en_high[u])
			);
		end
		for (c = 0; c < 8; c++) begin : g_chan
			// Channels 0-3 sit on unit 0, channels 4-7 on unit 1
			assign op_en[c] = clk_src_r[c] ? en_high[c/4] : en_low[c/4];
			ubrg_divider u_divider (
				.sys_clk   (sys_clk),
				.rstn      (rstn),
				.ce        (ce),
				.op_en     (op_en[c]),
				.run       (run_r[c]),
				.div       (div_r[c]),
				.frame_len (frame_r[c]),
				.rxd       (rxd[c]),
				.half_tick (half_tick[c]),
				.bit_tick  (bit_tick[c]),
				.rx_sample (rx_sample[c]),
				.rx_bit    (rx_bit[c]),
				.rx_done   (rx_frame_done[c]),
				.rx_err    (rx_frame_err[c]),
				.rx_busy   (rx_busy[c])
			);
		end
	endgenerate

	a_wait_one_cycle: assert property (@(posedge sys_clk) disable iff (!rstn)
		(ce && avs_waitrequest) |=> !avs_waitrequest)
		else $error("waitrequest held beyond one enabled cycle");
	a_stop_clears_run: assert property (@(posedge sys_clk) disable iff (!rstn)
		(ce && wr_take && avs_address == `UBRG_OFF_STOP && avs_byteenable[0])
		|=> ((run_r & $past(avs_writedata[7:0])) == 8'h00))
		else $error("stop write left a channel running");
	a_src_high_field: assert property (@(posedge sys_clk) disable iff (!rstn)
		(clk_src_r[0] && ps_r[0][7:4] == 4'hf) |-> (op_en[0] == timer2_event))
		else $error("channel 0 high field not routed to timer event");
	c_div_write: cover property (@(posedge sys_clk) disable iff (!rstn)
		wr_take && data_hit[3] ##[1:20] run_r[0]);
endmodule : ubrg_top

// ===== tb/ubrg_remote_tx.sv
`timescale 1ns/10ps
module ubrg_remote_tx (
	input  wire logic sys_clk,
	output logic      line
);
	// Mark level between frames, as a real line would rest
	initial line = 1'b1;
	// Bits go out first-index first; caller starts right after an edge
	task automatic send(input logic [15:0] bits, input int nbits, input int period);
		for (int i = 0; i < nbits; i++) begin
			line <= bits[i];
			repeat (period) @(posedge sys_clk);
		end
		line <= 1'b1;
	endtask : send
endmodule : ubrg_remote_tx

// ===== tb/test_uart_baud_rate_generator.sv
`timescale 1ns/10ps
`include "ubrg_params.svh"
module test_uart_baud_rate_generator;
	typedef struct {int ch; logic [7:0] ps; logic src; logic [6:0] dv; int hp;} ubrg_row_type;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        ce = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        timer2_event = 1'b0;
	logic        timer3_event = 1'b0;
	logic        tx_line;
	logic [7:0]  half_tick;
	logic [7:0]  bit_tick;
	logic [7:0]  rx_sample;
	logic [7:0]  rx_bit;
	logic [7:0]  rx_frame_done;
	logic [7:0]  rx_frame_err;
	logic [31:0] q;
	int          n_fail = 0;
	int          compares = 0;
	int          tc2 = 0;
	int          tc3 = 0;
	int          hp;
	int          bp;
	// Timer periods differ so a crossed unit shows as a wrong period
	ubrg_row_type rows [7] = '{
		'{0, 8'h00, 1'b0, 7'h02, 3},
		'{1, 8'h30, 1'b0, 7'h04, 5},
		'{2, 8'h30, 1'b1, 7'h04, 40},
		'{0, 8'h0b, 1'b0, 7'h02, 6144},
		'{3, 8'h01, 1'b0, 7'h7f, 256},
		'{0, 8'h0f, 1'b0, 7'h03, 20},
		'{5, 8'hf0, 1'b1, 7'h02, 12}
	};

	always #12.5 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		tc2 <= (tc2 == 4) ? 0 : tc2 + 1;
		tc3 <= (tc3 == 3) ? 0 : tc3 + 1;
		timer2_event <= (tc2 == 0);
		timer3_event <= (tc3 == 0);
	end

	ubrg_top uut (
		.sys_clk        (sys_clk),
		.rstn           (rstn),
		.ce             (ce),
		.avs_address    (avs_address),
		.avs_read       (avs_read),
		.avs_write      (avs_write),
		.avs_writedata  (avs_writedata),
		.avs_byteenable (avs_byteenable),
		.avs_readdata   (avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.timer2_event   (timer2_event),
		.timer3_event   (timer3_event),
		.rxd            ({7'h7f, tx_line}),
		.half_tick      (half_tick),
		.bit_tick       (bit_tick),
		.rx_sample      (rx_sample),
		.rx_bit         (rx_bit),
		.rx_frame_done  (rx_frame_done),
		.rx_frame_err   (rx_frame_err)
	);

	ubrg_remote_tx tx (
		.sys_clk(sys_clk),
		.line   (tx_line)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	// One transfer; an idle edge follows so the next request starts clean
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
		if (n >= 20) check(32'(n), 32'h1, "bus wait");
	endtask : bus

	task automatic cfg(input int ch, input logic [7:0] ps, input logic src, input logic [6:0] dv);
		bus(1'b1, `UBRG_OFF_STOP, 32'h0000_00ff);
		bus(1'b1, (ch > 3) ? `UBRG_OFF_PRESCALE1 : `UBRG_OFF_PRESCALE0, {24'h0, ps});
		bus(1'b1, `UBRG_OFF_MODE_BASE + 8'(4 * ch), {16'h0, src, 11'h0, 4'ha});
		bus(1'b1, `UBRG_OFF_DATA_BASE + 8'(4 * ch), {16'h0, dv, 9'h0});
		bus(1'b1, `UBRG_OFF_START, 32'h1 << ch);
	endtask : cfg

	task automatic measure(input int ch);
		int n;
		n = 0;
		hp = 0;
		while (bit_tick[ch] !== 1'b1 && n < 40000) begin
			@(posedge sys_clk);
			n++;
		end
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (half_tick[ch] === 1'b1 && hp == 0) hp = n;
		end while (bit_tick[ch] !== 1'b1 && n < 40000);
		bp = n;
	endtask : measure

	task automatic rx_frame(input logic [9:0] fr, input logic err);
		logic [9:0] got;
		logic       e;
		int         k;
		int         n;
		got = 10'h0;
		e = 1'b0;
		k = 0;
		n = 0;
		fork
			tx.send({6'h0, fr}, 10, 6);
			do begin
				@(posedge sys_clk);
				n++;
				if (rx_sample[0] === 1'b1 && k < 10) begin
					got[k] = rx_bit[0];
					k++;
				end
				// The error flag is a pulse beside done, gone before the stop bit ends
				if (rx_frame_done[0] === 1'b1)
					e = rx_frame_err[0];
			end while (rx_frame_done[0] !== 1'b1 && n < 200);
		join
		check(32'(k), 32'd10, "sample count");
		check({22'h0, got}, {22'h0, fr}, "frame bits");
		check({31'h0, e}, {31'h0, err}, "frame err");
	endtask : rx_frame

	initial begin
		repeat (90000) @(posedge sys_clk);
		n_fail++;
		summarize();
	end

	initial begin
		repeat (5) @(posedge sys_clk);
		check({24'h0, half_tick}, 32'h0, "tick in reset");
		check({24'h0, rx_bit}, 32'hff, "rx_bit in reset");
		@(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		bus(1'b0, `UBRG_OFF_PRESCALE0, 32'h0);
		check(q, 32'h0, "prescale reset");
		bus(1'b0, `UBRG_OFF_MODE_BASE, 32'h0);
		check(q, 32'h0000_000a, "mode reset");
		bus(1'b0, `UBRG_OFF_DATA_BASE, 32'h0);
		check(q, 32'h0000_8000, "divider reset");
		bus(1'b0, 8'hfc, 32'h0);
		check(q, 32'h0, "unmapped read");
		$display("register test done");
		foreach (rows[i]) begin
			cfg(rows[i].ch, rows[i].ps, rows[i].src, rows[i].dv);
			measure(rows[i].ch);
			check(32'(hp), 32'(rows[i].hp), "half period");
			check(32'(bp), 32'(2 * rows[i].hp), "bit period");
			$display("row %0d done", i);
		end
		bus(1'b0, `UBRG_OFF_DATA_BASE + 8'h14, 32'h0);
		check(q, 32'h0000_0400, "divider readback");
		cfg(0, 8'h00, 1'b0, 7'h02);
		// A one-cycle dip must be dropped as a false start
		tx.send(16'h0, 1, 1);
		repeat (4) @(posedge sys_clk);
		rx_frame({1'b1, 8'ha5, 1'b0}, 1'b0);
		repeat (3) @(posedge sys_clk);
		rx_frame({1'b0, 8'h3c, 1'b0}, 1'b1);
		$display("receive test done");
		summarize();
	end
endmodule : test_uart_baud_rate_generator
